// [design/ssw_pkg.sv]
/*
 Constants, register map and carrier types for the supply supervisor with
 watchdog. Assumes a 20 MHz core clock and a plain one-cycle register port.
*/
// Notes on behaviour
// RL1 - Supply below detect level drives the reset output low, watchdog or not.
// RL2 - After supply returns, reset stays low for the release delay, then releases.
// RL3 - No kick edge within the timeout gives a reset pulse of release delay length.
// RL4 - Kick input is pulled low, so an open kick pin gives periodic resets.
// RL5 - Timeout is one of 1.6 s, 800, 400, 200, 100 or 50 ms.
// RL6 - Release delay is one of 400, 200, 100, 50 or 3.13 ms.
// RL7 - High-active enable: low level stops only the watchdog, detection continues.
// RL8 - Low-active enable: high level stops only the watchdog, detection continues.
// RL9 - When supply and enable both return, full release delay still applies.
// RL10 - Watchdog restarts timing at once when supply is good and enable active.
// RL11 - Reset is entered a short detect delay after the supply falls.
// RL12 - Kick edges inside a blanking time of at most 900 us are ignored.
// RL13 - Processor holds each kick level at least 300 ns.
// RL14 - High-active enable with pull-up: open pin leaves the watchdog on.
// RL15 - Low-active enable with pull-down: open pin leaves the watchdog on.
// RL16 - Integrator chooses a release delay no longer than the timeout.
// RL17 - While supply is low, reset stays low whatever kick or enable do.
// RL18 - Each accepted kick edge restarts the timeout count from zero.
package ssw_pkg;

	// Clock and counter width
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned CW            = 26;

	// Watchdog timeouts in microseconds
	localparam int unsigned TO_1600_US = 1600000;
	localparam int unsigned TO_800_US  = 800000;
	localparam int unsigned TO_400_US  = 400000;
	localparam int unsigned TO_200_US  = 200000;
	localparam int unsigned TO_100_US  = 100000;
	localparam int unsigned TO_50_US   = 50000;
	localparam logic [CW-1:0] TO_1600_CYC = CW'(TO_1600_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] TO_800_CYC  = CW'(TO_800_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] TO_400_CYC  = CW'(TO_400_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] TO_200_CYC  = CW'(TO_200_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] TO_100_CYC  = CW'(TO_100_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] TO_50_CYC   = CW'(TO_50_US * 1000 / CLK_PERIOD_NS);

	// Release delays in microseconds (3.13 ms as 3130 us)
	localparam int unsigned RD_400_US = 400000;
	localparam int unsigned RD_200_US = 200000;
	localparam int unsigned RD_100_US = 100000;
	localparam int unsigned RD_50_US  = 50000;
	localparam int unsigned RD_3_US   = 3130;
	localparam logic [CW-1:0] RD_400_CYC = CW'(RD_400_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] RD_200_CYC = CW'(RD_200_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] RD_100_CYC = CW'(RD_100_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] RD_50_CYC  = CW'(RD_50_US * 1000 / CLK_PERIOD_NS);
	localparam logic [CW-1:0] RD_3_CYC   = CW'(RD_3_US * 1000 / CLK_PERIOD_NS);

	// Detect delay, longest 33 us, rounded down
	localparam int unsigned   DET_NS  = 33000;
	localparam logic [CW-1:0] DET_CYC = CW'(DET_NS / CLK_PERIOD_NS);

	// Kick blanking, at most 900 us, rounded down
	localparam int unsigned   BLANK_US  = 900;
	localparam logic [CW-1:0] BLANK_CYC = CW'(BLANK_US * 1000 / CLK_PERIOD_NS);

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_INT_STAT = 8'h08;
	localparam logic [7:0] OFS_INT_CLR  = 8'h0C;
	localparam logic [7:0] OFS_INT_EN   = 8'h10;

	// Interrupt bit positions
	localparam int unsigned IRQ_DROP    = 0;
	localparam int unsigned IRQ_TIMEOUT = 1;
	localparam int unsigned IRQ_RELEASE = 2;

	// Control register layout, bits [15:0]
	typedef struct packed {
		logic [5:0] rsvd;
		logic       en_pull;
		logic       en_active_low;
		logic       rsvd_b;
		logic [2:0] rel_sel;
		logic       rsvd_a;
		logic [2:0] to_sel;
	} ssw_ctrl_t;

	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [2:0]  INT_EN_RESET = 3'h0;

	// Supervisor states
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_DFALL = 2'b01,
		ST_LOW   = 2'b10,
		ST_HOLD  = 2'b11
	} ssw_state_t;

endpackage

// [design/ssw_kick_filter.sv]
/*
 Kick input conditioner: pull-down model, two-flop synchroniser, edge
 detection and blanking. Assumes the kick pin is asynchronous to core_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module ssw_kick_filter #(
	parameter logic [ssw_pkg::CW-1:0] P_BLANK_CYC = ssw_pkg::BLANK_CYC
) (
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	// Pin side
	input  wire logic kick_input_in,
	input  wire logic kick_float_in,
	// Core side
	output logic      kick_edge_out
);

	logic [1:0]              sync1_ff;
	logic [1:0]              sync2_ff;
	logic                    pin_lvl;
	logic                    last_ff;
	logic [ssw_pkg::CW-1:0]  blank_ff;
	logic                    raw_edge;

	////////////////////////////////////////////////////////////////////////
	// Level and open flag synchronised apart; gating raw pins could glitch
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sync1_ff <= 2'b00;
			sync2_ff <= 2'b00;
		end
		else
		begin
			sync1_ff <= {kick_float_in, kick_input_in};
			sync2_ff <= sync1_ff;
		end
	end

	// Open pin reads low through the internal pull-down
	assign pin_lvl = sync2_ff[0] & ~sync2_ff[1]; // RL4

	// Level tracked always, so a bounce settles back without a late edge
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			last_ff <= 1'b0;
		else
			last_ff <= pin_lvl;
	end

	assign raw_edge = pin_lvl ^ last_ff;

	// Blanking window opened by each accepted edge
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			blank_ff <= '0;
		else if (raw_edge && blank_ff == '0)
			blank_ff <= P_BLANK_CYC; // RL12
		else if (blank_ff != '0)
			blank_ff <= blank_ff - 1'b1;
	end

	assign kick_edge_out = raw_edge && blank_ff == '0; // RL12

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	a_blank_quiet: assert property (kick_edge_out |=> !kick_edge_out [*2]) // RL12
		else $error("kick edge accepted inside blanking window");

endmodule
`default_nettype wire

// [design/ssw_top.sv]
/*
 Supply supervisor with watchdog: reset state machine, watchdog counter,
 register port and interrupt. Assumes a supply comparator level, enable and
 kick pins arriving asynchronously, and an external pull-up on the reset pin.
*/
`timescale 1ns/1ps
`default_nettype none
module ssw_top #(
	parameter logic [ssw_pkg::CW-1:0] P_TO_1600_CYC = ssw_pkg::TO_1600_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_TO_800_CYC  = ssw_pkg::TO_800_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_TO_400_CYC  = ssw_pkg::TO_400_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_TO_200_CYC  = ssw_pkg::TO_200_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_TO_100_CYC  = ssw_pkg::TO_100_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_TO_50_CYC   = ssw_pkg::TO_50_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_RD_400_CYC  = ssw_pkg::RD_400_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_RD_200_CYC  = ssw_pkg::RD_200_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_RD_100_CYC  = ssw_pkg::RD_100_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_RD_50_CYC   = ssw_pkg::RD_50_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_RD_3_CYC    = ssw_pkg::RD_3_CYC,
	parameter logic [ssw_pkg::CW-1:0] P_BLANK_CYC   = ssw_pkg::BLANK_CYC
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	// Supply comparator, high while supply is above release level
	input  wire logic        supply_ok_in,
	// Watchdog pins
	input  wire logic        kick_input_in,
	input  wire logic        kick_float_in,
	input  wire logic        en_pin_in,
	input  wire logic        en_float_in,
	// Open-drain reset pin
	input  wire logic        reset_out_n_in,
	output logic             reset_out_n_out,
	output logic             reset_out_n_oe_out,
	// Register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic [31:0]      reg_rdata_out,
	// Interrupt
	output logic             irq_out
);

	localparam int unsigned CW = ssw_pkg::CW;

	ssw_pkg::ssw_ctrl_t  ctrl_ff;
	ssw_pkg::ssw_state_t state_ff;
	ssw_pkg::ssw_state_t nxt_state;
	logic [3:0]          sync1_ff;
	logic [3:0]          sync2_ff;
	logic [CW-1:0]       cnt_ff;
	logic [CW-1:0]       wd_cnt_ff;
	logic [CW-1:0]       to_cyc;
	logic [CW-1:0]       rel_cyc;
	logic [2:0]          int_stat_ff;
	logic [2:0]          int_en_ff;
	logic [2:0]          int_set;
	logic [31:0]         rdata_ff;
	logic                supply_s;
	logic                en_s;
	logic                en_float_s;
	logic                pin_s;
	logic                wd_on;
	logic                kick_edge;
	logic                wd_expire;

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for every asynchronous level
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end
		else
		begin
			sync1_ff <= {reset_out_n_in, en_float_in, en_pin_in, supply_ok_in};
			sync2_ff <= sync1_ff;
		end
	end

	assign supply_s   = sync2_ff[0];
	assign en_s       = sync2_ff[1];
	assign en_float_s = sync2_ff[2];
	assign pin_s      = sync2_ff[3];

	// Kick conditioning lives in its own module
	ssw_kick_filter #(
		.P_BLANK_CYC(P_BLANK_CYC)
	) u_kick (
		.core_clk_in  (core_clk_in),
		.rst_in       (rst_in),
		.kick_input_in(kick_input_in),
		.kick_float_in(kick_float_in),
		.kick_edge_out(kick_edge)
	);

	////////////////////////////////////////////////////////////////////////
	// Enable decode; an open pin with pull fitted counts as active
	always_comb
	begin
		if (en_float_s && ctrl_ff.en_pull)
			wd_on = 1'b1; // RL14 RL15
		else if (ctrl_ff.en_active_low)
			wd_on = ~en_s; // RL8
		else
			wd_on = en_s; // RL7
	end

	// Timeout selection; codes above five fall back to the shortest
	always_comb
	begin
		case (ctrl_ff.to_sel) // RL5
			3'h0:    to_cyc = P_TO_1600_CYC;
			3'h1:    to_cyc = P_TO_800_CYC;
			3'h2:    to_cyc = P_TO_400_CYC;
			3'h3:    to_cyc = P_TO_200_CYC;
			3'h4:    to_cyc = P_TO_100_CYC;
			default: to_cyc = P_TO_50_CYC;
		endcase
	end

	// Release delay selection; codes above four fall back to 3.13 ms
	always_comb
	begin
		case (ctrl_ff.rel_sel) // RL6
			3'h0:    rel_cyc = P_RD_400_CYC;
			3'h1:    rel_cyc = P_RD_200_CYC;
			3'h2:    rel_cyc = P_RD_100_CYC;
			3'h3:    rel_cyc = P_RD_50_CYC;
			default: rel_cyc = P_RD_3_CYC;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog counter only runs while released, enabled and supplied
	assign wd_expire = state_ff == ssw_pkg::ST_RUN && wd_on && supply_s && !kick_edge
		&& wd_cnt_ff == to_cyc - 1'b1;

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			wd_cnt_ff <= '0;
		else if (state_ff != ssw_pkg::ST_RUN || !wd_on)
			wd_cnt_ff <= '0; // RL7 RL8 RL10
		else if (kick_edge || wd_expire)
			wd_cnt_ff <= '0; // RL18
		else
			wd_cnt_ff <= wd_cnt_ff + 1'b1; // RL3
	end

	////////////////////////////////////////////////////////////////////////
	// Reset sequencing; supply loss outranks every watchdog event
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ssw_pkg::ST_RUN:
				if (!supply_s)
					nxt_state = ssw_pkg::ST_DFALL; // RL11
				else if (wd_expire)
					nxt_state = ssw_pkg::ST_HOLD; // RL3
			ssw_pkg::ST_DFALL:
				if (supply_s)
					nxt_state = ssw_pkg::ST_RUN;
				else if (cnt_ff == ssw_pkg::DET_CYC - 1'b1)
					nxt_state = ssw_pkg::ST_LOW; // RL1 RL11
			ssw_pkg::ST_LOW:
				if (supply_s)
					nxt_state = ssw_pkg::ST_HOLD; // RL2 RL9
			ssw_pkg::ST_HOLD:
				if (!supply_s)
					nxt_state = ssw_pkg::ST_LOW; // RL17
				else if (cnt_ff == rel_cyc - 1'b1)
					nxt_state = ssw_pkg::ST_RUN; // RL2
			default:
				nxt_state = ssw_pkg::ST_LOW;
		endcase
	end

	// Power-up starts in the low state, as a cold supply would
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			state_ff <= ssw_pkg::ST_LOW;
		else
			state_ff <= nxt_state;
	end

	// Shared counter for detect delay and release delay
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			cnt_ff <= '0;
		else if (nxt_state != state_ff)
			cnt_ff <= '0;
		else if (state_ff == ssw_pkg::ST_DFALL || state_ff == ssw_pkg::ST_HOLD)
			cnt_ff <= cnt_ff + 1'b1;
	end

	// Open drain: pull low in the low and hold states only
	assign reset_out_n_out    = 1'b0;
	assign reset_out_n_oe_out = state_ff[1]; // RL1 RL17

	////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ctrl_ff   <= ssw_pkg::CTRL_RESET;
			int_en_ff <= ssw_pkg::INT_EN_RESET;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == ssw_pkg::OFS_CTRL)
				ctrl_ff <= reg_wdata_in[15:0] & 16'h0377;
			else if (reg_addr_in == ssw_pkg::OFS_INT_EN)
				int_en_ff <= reg_wdata_in[2:0];
		end
	end

	// Sticky events; a new event wins over a same-cycle clear
	always_comb
	begin
		int_set = 3'h0;
		int_set[ssw_pkg::IRQ_DROP]    = nxt_state == ssw_pkg::ST_LOW
			&& state_ff != ssw_pkg::ST_LOW;
		int_set[ssw_pkg::IRQ_TIMEOUT] = wd_expire;
		int_set[ssw_pkg::IRQ_RELEASE] = state_ff == ssw_pkg::ST_HOLD
			&& nxt_state == ssw_pkg::ST_RUN;
	end

	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			int_stat_ff <= 3'h0;
		else if (reg_wr_in && reg_addr_in == ssw_pkg::OFS_INT_CLR)
			int_stat_ff <= (int_stat_ff & ~reg_wdata_in[2:0]) | int_set;
		else
			int_stat_ff <= int_stat_ff | int_set;
	end

	assign irq_out = |(int_stat_ff & int_en_ff);

	// Read data stands for one cycle only; unmapped reads return zero
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_ff <= 32'h0000_0000;
		else if (!reg_rd_in)
			rdata_ff <= 32'h0000_0000;
		else if (reg_addr_in == ssw_pkg::OFS_CTRL)
			rdata_ff <= {16'h0000, ctrl_ff};
		else if (reg_addr_in == ssw_pkg::OFS_STATUS)
			rdata_ff <= {26'h000_0000, state_ff, pin_s, wd_on, supply_s,
				reset_out_n_oe_out};
		else if (reg_addr_in == ssw_pkg::OFS_INT_STAT)
			rdata_ff <= {29'h0000_0000, int_stat_ff};
		else if (reg_addr_in == ssw_pkg::OFS_INT_EN)
			rdata_ff <= {29'h0000_0000, int_en_ff};
		else
			rdata_ff <= 32'h0000_0000;
	end

	assign reg_rdata_out = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	a_low_drives_reset: assert property ( // RL1
		state_ff == ssw_pkg::ST_LOW |-> reset_out_n_oe_out && !reset_out_n_out)
		else $error("reset not driven low during supply loss");

	a_low_holds_reset: assert property ( // RL17
		!supply_s && state_ff == ssw_pkg::ST_HOLD |=> state_ff == ssw_pkg::ST_LOW
		&& reset_out_n_oe_out)
		else $error("supply loss during hold did not keep reset low");

	a_detect_bound: assert property ( // RL11
		state_ff == ssw_pkg::ST_DFALL |-> cnt_ff < ssw_pkg::DET_CYC)
		else $error("detect delay overran");

	a_hold_exit: assert property ( // RL2
		state_ff == ssw_pkg::ST_HOLD && supply_s && cnt_ff == rel_cyc - 1'b1
		|=> state_ff == ssw_pkg::ST_RUN && !reset_out_n_oe_out)
		else $error("reset not released at end of release delay");

	a_hold_full: assert property ( // RL9
		$rose(state_ff == ssw_pkg::ST_RUN) && $past(state_ff) == ssw_pkg::ST_HOLD
		|-> $past(cnt_ff) == rel_cyc - 1'b1)
		else $error("reset released before full release delay");

	a_wd_expire: assert property ( // RL3
		wd_expire |=> state_ff == ssw_pkg::ST_HOLD ##1 reset_out_n_oe_out)
		else $error("watchdog expiry did not start reset");

	a_wd_bound: assert property ( // RL5
		state_ff == ssw_pkg::ST_RUN |-> wd_cnt_ff < to_cyc)
		else $error("watchdog count beyond selected timeout");

	a_wd_forced_off: assert property ( // RL7
		!wd_on |=> wd_cnt_ff == '0 && state_ff != ssw_pkg::ST_HOLD
		|| $past(state_ff) != ssw_pkg::ST_RUN)
		else $error("watchdog ran while forced off");

	a_kick_restart: assert property ( // RL18
		kick_edge && wd_on && state_ff == ssw_pkg::ST_RUN |=> wd_cnt_ff == '0)
		else $error("kick edge did not restart the timeout");

	a_open_enable: assert property ( // RL14
		en_float_s && ctrl_ff.en_pull |-> wd_on)
		else $error("open enable pin with pull disabled the watchdog");

	c_wd_timeout: cover property (wd_expire ##1 state_ff == ssw_pkg::ST_HOLD);
	c_supply_drop: cover property (state_ff == ssw_pkg::ST_DFALL
		##1 state_ff == ssw_pkg::ST_LOW);
	c_kick_seen: cover property (kick_edge && state_ff == ssw_pkg::ST_RUN && wd_on);
	c_release: cover property (state_ff == ssw_pkg::ST_HOLD
		##1 state_ff == ssw_pkg::ST_RUN);

endmodule
`default_nettype wire

// [sim/ssw_cpu_model.sv]
/*
 Monitored processor model: toggles the kick pin with a set gap.
 Assumes the supervisor samples the pin on core_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	// Control from the bench
	input  wire logic        active_in,
	input  wire logic [15:0] gap_in,
	// Kick pin
	output logic             kick_out,
	output logic             kick_open_out
);
	logic [15:0] gap_eff;
	logic [15:0] cnt_ff;

	// Gaps under six cycles would break the minimum level time
	assign gap_eff = (gap_in < 16'h0006) ? 16'h0006 : gap_in;

	// Toggle generator; a released pin sits at its pull-down level
	always_ff @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_ff   <= 16'h0000;
			kick_out <= 1'b0;
		end
		else if (!active_in)
		begin
			cnt_ff   <= 16'h0000;
			kick_out <= 1'b0;
		end
		else if (cnt_ff >= gap_eff)
		begin
			cnt_ff   <= 16'h0000;
			kick_out <= ~kick_out;
		end
		else
		begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// Pin counts as open whenever nobody drives it
	assign kick_open_out = ~active_in;
endmodule
`default_nettype wire

// [sim/tb_ssw_top.sv]
/*
 Self-checking bench for the supervisor: timeouts, kicks, enable, supply.
 Assumes shortened counts via parameters and a pulled-up reset pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_ssw_top;
	logic        core_clk_in = 1'b0;
	logic        rst_in      = 1'b1;
	logic        supply_ok   = 1'b1;
	logic        en_pin      = 1'b1;
	logic        en_float    = 1'b0;
	logic [7:0]  addr        = 8'h00;
	logic [31:0] wdata       = 32'h0000_0000;
	logic        wr          = 1'b0;
	logic        rd          = 1'b0;
	logic        cpu_act     = 1'b0;
	logic [15:0] cpu_gap     = 16'h0006;
	logic [31:0] rdata;
	logic        irq;
	logic        oe;
	logic        kick;
	logic        kick_open;
	wire         rst_pin_n;
	int          errors      = 0;
	int          tests_run   = 0;
	logic        rst_dat;
	// Shortened counts; release delays all below the shortest timeout
	localparam int TO_C [6]  = '{400, 300, 200, 150, 120, 100};
	localparam int RD_C [5]  = '{60, 50, 40, 30, 20};
	localparam int BLANK_C   = 4;

	// Open drain pin with pull-up; pin shows the data only while driven
	assign rst_pin_n = oe ? rst_dat : 1'b1;

	always #25 core_clk_in = ~core_clk_in;

	// Release delays all below the shortest timeout
	ssw_top #(
		.P_TO_1600_CYC(26'(TO_C[0])), .P_TO_800_CYC(26'(TO_C[1])), .P_TO_400_CYC(26'(TO_C[2])),
		.P_TO_200_CYC(26'(TO_C[3])), .P_TO_100_CYC(26'(TO_C[4])), .P_TO_50_CYC(26'(TO_C[5])),
		.P_RD_400_CYC(26'(RD_C[0])), .P_RD_200_CYC(26'(RD_C[1])), .P_RD_100_CYC(26'(RD_C[2])),
		.P_RD_50_CYC(26'(RD_C[3])), .P_RD_3_CYC(26'(RD_C[4])), .P_BLANK_CYC(26'(BLANK_C))
	) ssw_top_inst (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .supply_ok_in(supply_ok),
		.kick_input_in(kick), .kick_float_in(kick_open), .en_pin_in(en_pin),
		.en_float_in(en_float), .reset_out_n_in(rst_pin_n), .reset_out_n_out(rst_dat),
		.reset_out_n_oe_out(oe), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq)
	);

	ssw_cpu_model ssw_cpu_model_inst (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .active_in(cpu_act),
		.gap_in(cpu_gap), .kick_out(kick), .kick_open_out(kick_open)
	);

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic chk_rng(input int n, input int lo, input int hi);
		chk({31'h0, (n >= lo && n <= hi)}, 32'h0000_0001);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge core_clk_in);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_in);
		addr <= a;
		rd   <= 1'b1;
		@(posedge core_clk_in);
		rd <= 1'b0;
		@(negedge core_clk_in);
		d = rdata;
	endtask

	task automatic set_ctrl(input int to, input int rl, input bit alow, input bit pull);
		ssw_pkg::ssw_ctrl_t c;
		c               = '0;
		c.to_sel        = 3'(to);
		c.rel_sel       = 3'(rl);
		c.en_active_low = alow;
		c.en_pull       = pull;
		wr_reg(ssw_pkg::OFS_CTRL, {16'h0000, c});
	endtask

	// Cycles until the pull-down enable reaches a level, bounded
	task automatic wait_oe(input logic lvl, input int lim, output int n);
		n = 0;
		while (oe !== lvl && n < lim)
		begin
			@(negedge core_clk_in);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		logic [31:0] d;
		int          n;
		chk(oe, 1'b1);
		rst_in <= 1'b0;
		rd_reg(ssw_pkg::OFS_CTRL, d);
		chk(d, 32'h0000_0000);
		rd_reg(ssw_pkg::OFS_INT_EN, d);
		chk(d, 32'h0000_0000);
		rd_reg(8'h20, d);
		chk(d, 32'h0000_0000);
		wait_oe(1'b0, 200, n);
		chk_rng(n, 55, 66);
	endtask

	// Open kick pin: every timeout code with a release code each
	task automatic t_timeouts;
		int n;
		for (int i = 0; i < 6; i++)
		begin
			set_ctrl(i, (i < 5) ? i : 4, 1'b0, 1'b0);
			wait_oe(1'b1, 500, n);
			wait_oe(1'b0, 100, n);
			wait_oe(1'b1, 500, n);
			chk_rng(n, TO_C[i] - 2, TO_C[i] + 3);
			wait_oe(1'b0, 100, n);
			chk(32'(n), 32'(RD_C[(i < 5) ? i : 4]));
		end
	endtask

	// Regular kicks near the limit keep reset released
	task automatic t_kick;
		int n;
		set_ctrl(0, 0, 1'b0, 1'b0);
		wait_oe(1'b0, 600, n);
		cpu_gap <= 16'h015E;
		cpu_act <= 1'b1;
		wait_oe(1'b1, 1500, n);
		chk(32'(n), 32'd1500);
	endtask

	task automatic t_enable;
		int n;
		@(posedge core_clk_in);
		cpu_act <= 1'b0;
		en_pin  <= 1'b0;
		wait_oe(1'b1, 1200, n);
		chk(32'(n), 32'd1200);
		@(posedge core_clk_in);
		en_pin <= 1'b1;
		wait_oe(1'b1, 500, n);
		chk_rng(n, TO_C[0] - 2, TO_C[0] + 6);
		wait_oe(1'b0, 100, n);
		set_ctrl(0, 0, 1'b1, 1'b0);
		wait_oe(1'b1, 1200, n);
		chk(32'(n), 32'd1200);
		@(posedge core_clk_in);
		en_float <= 1'b1;
		set_ctrl(0, 0, 1'b1, 1'b1);
		wait_oe(1'b1, 500, n);
		chk_rng(n, TO_C[0] - 2, TO_C[0] + 6);
		wait_oe(1'b0, 100, n);
		set_ctrl(0, 0, 1'b0, 1'b1);
		wait_oe(1'b1, 500, n);
		chk_rng(n, TO_C[0] - 2, TO_C[0] + 6);
		wait_oe(1'b0, 100, n);
		@(posedge core_clk_in);
		en_float <= 1'b0;
	endtask

	// Supply drop while kicked, then enable and supply return together
	task automatic t_supply;
		int n;
		cpu_gap <= 16'h0032;
		cpu_act <= 1'b1;
		@(posedge core_clk_in);
		supply_ok <= 1'b0;
		wait_oe(1'b1, 800, n);
		chk_rng(n, 660, 668);
		@(posedge core_clk_in);
		cpu_act <= 1'b0;
		en_pin  <= 1'b0;
		wait_oe(1'b0, 1000, n);
		chk(32'(n), 32'd1000);
		@(posedge core_clk_in);
		supply_ok <= 1'b1;
		en_pin    <= 1'b1;
		wait_oe(1'b0, 200, n);
		chk_rng(n, 60, 64);
	endtask

	// Timeout event: raise, mask, unmask and clear the interrupt
	task automatic t_irq;
		logic [31:0] d;
		int          n;
		wr_reg(ssw_pkg::OFS_INT_CLR, 32'h0000_0007);
		wr_reg(ssw_pkg::OFS_INT_EN, 32'h0000_0002);
		wait_oe(1'b1, 500, n);
		@(negedge core_clk_in);
		chk(irq, 1'b1);
		rd_reg(ssw_pkg::OFS_INT_STAT, d);
		chk(d, 32'h0000_0002);
		// Hold state, supply and watchdog on, pin read back low
		rd_reg(ssw_pkg::OFS_STATUS, d);
		chk(d, 32'h0000_0037);
		wr_reg(ssw_pkg::OFS_INT_EN, 32'h0000_0000);
		@(negedge core_clk_in);
		chk(irq, 1'b0);
		wr_reg(ssw_pkg::OFS_INT_EN, 32'h0000_0002);
		@(negedge core_clk_in);
		chk(irq, 1'b1);
		wr_reg(ssw_pkg::OFS_INT_CLR, 32'h0000_0002);
		@(negedge core_clk_in);
		chk(irq, 1'b0);
		// Supply dip inside the watchdog hold restarts the full release delay
		@(posedge core_clk_in);
		supply_ok <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		supply_ok <= 1'b1;
		wait_oe(1'b0, 200, n);
		chk_rng(n, 63, 65);
		rd_reg(ssw_pkg::OFS_INT_STAT, d);
		chk(d, 32'h0000_0005);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict and run control
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence; reset held for four cycles
	initial
	begin
		repeat (4) @(posedge core_clk_in);
		t_reset();
		t_timeouts();
		t_kick();
		t_enable();
		t_supply();
		t_irq();
		summarize();
	end

	// Hang guard, well above the expected run of about 10600 cycles
	initial
	begin
		repeat (40000) @(posedge core_clk_in);
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
